/* File: itc_carrier_gen.sv */
// Programmable-length pattern shift register driving a complementary carrier.
// Assumes pattern writes are single-cycle strobes from the register port.
`timescale 1ns/1ns
`include "itc_defines.svh"
module itc_carrier_gen (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic patWrite,
    input wire logic [15:0] patData,
    input wire logic enable,
    input wire logic [9:0] lengthCount,
    input wire logic [15:0] divider,
    output logic carrierTrue,
    output logic carrierInverse
);
    itc_pkg::itc_carrier_s q, d;
    logic [15:0] divLast;

    always_comb
    begin
        d = q;
        // A divider of zero would never advance, so it runs as one
        divLast = (divider == 16'h0000) ? 16'h0000 : divider - 16'h0001;
        if (patWrite)
        begin
            d.loaded = 1'b1;
            if (q.loaded)
                d.pattern = {q.pattern[1007:0], patData};
            else
                d.pattern = {1008'h0, patData};
        end
        if (!enable)
        begin
            d.divCnt = 16'h0000;
            d.bitPtr = lengthCount;
            d.outTrue = 1'b0;
            d.outInv = 1'b0;
        end
        else if (q.divCnt >= divLast)
        begin
            d.divCnt = 16'h0000;
            d.outTrue = q.pattern[q.bitPtr];
            d.outInv = ~q.pattern[q.bitPtr];
            if (q.bitPtr == 10'h000 || q.bitPtr > lengthCount)
                d.bitPtr = lengthCount;
            else
                d.bitPtr = q.bitPtr - 10'h001;
        end
        else
            d.divCnt = q.divCnt + 16'h0001;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            q <= '0;
        else if (ce)
            q <= d;
    end

    assign carrierTrue = q.outTrue;
    assign carrierInverse = q.outInv;

    a_carrier_compl: assert property (@(posedge clk) disable iff (srst)
        q.outTrue |-> !q.outInv)
        else $error("carrier outputs not complementary");
    a_carrier_off: assert property (@(posedge clk) disable iff (srst)
        ($past(ce) && !$past(enable)) |-> !q.outTrue && !q.outInv)
        else $error("carrier drives while disabled");
    c_carrier_run: cover property (@(posedge clk) disable iff (srst) $rose(q.outTrue));
endmodule

/* File: itc_defines.svh */
// Offsets, field positions, reset values and limits of the integrator channel.
// Included by the package user files; definitions only.
`ifndef ITC_DEFINES_SVH
`define ITC_DEFINES_SVH
`define ITC_ADDR_CTRL 4'h0
`define ITC_ADDR_RATIO 4'h1
`define ITC_ADDR_DATA 4'h2
`define ITC_ADDR_TIME 4'h3
`define ITC_ADDR_STATUS 4'h4
`define ITC_ADDR_PATTERN 4'h5
`define ITC_ADDR_LENGTH 4'h6
`define ITC_ADDR_DIVIDER 4'h7
`define ITC_CTRL_INT_ON 0
`define ITC_CTRL_HOLD_MODE 1
`define ITC_CTRL_NARROW 2
`define ITC_CTRL_FILT_ON 3
`define ITC_CTRL_DEMOD 4
`define ITC_CTRL_TMODE 5
`define ITC_CTRL_HSEL 6
`define ITC_CTRL_SYNC 7
`define ITC_CTRL_ORDER_LO 8
`define ITC_CTRL_SLICE_LO 16
`define ITC_RATIO_INT_LO 0
`define ITC_RATIO_SINC_LO 8
`define ITC_DIV_EN 16
`define ITC_RST_VALUE 32'h0000_0000
`define ITC_ORDER_FIRST 2'h1
`define ITC_SINC_RATIO_ONE 9'h001
`define ITC_INT_RATIO_MAX 8'h80
`define ITC_ACC_POS 34'h0_8000_0000
`define ITC_ACC_NEG 34'h3_8000_0000
`define ITC_TIME_MAX 16'hFFFF
`define ITC_PAT_BITS 1024
`define ITC_PAT_CHUNK 16
`endif

/* File: itc_integrator_top.sv */
// Integrator channel: register port, 32-bit accumulator, 16-bit slice,
// time meter and carrier generator. Assumes sinc output, modulator bit and
// clock, hold triggers and calibration status are synchronous to clk.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`include "itc_defines.svh"
// Function
// - Oversampling mode sums 1 to 128 sinc words, one per word.
// - Oversampling mode restarts integration when the sinc filter becomes enabled.
// - Rising sync start bit restarts accumulation together in all channels.
// - Oversampling mode flags overflow when magnitude reaches or passes the maximum.
// - Sample-and-hold mode flags overflow when magnitude exceeds 2,147,483,648.
// - After overflow the accumulator clears and integration keeps running.
// - Narrow select presents a 16-bit slice chosen by the slice offset.
// - The 16-bit slice always carries the sign of the full word.
// - Filter enable, first order and ratio one feed raw modulator bits.
// - Demodulation runs only with its enable set and calibration finished.
// - Time counter is 16 bits, counting modulator or system clocks.
// - Timer mode one latches modulator clocks between hold edges, then zeros.
// - Timer mode zero counts system clocks, zeroed by new data, latched on hold.
// - Wrap flag sets on rollover from 0xFFFF and clears on status read.
// - Carrier is a 1 to 1024 bit shift register with complementary outputs.
// - First pattern write loads low 16 bits; later writes shift up 16.
// - Pattern length count holds the length minus one.
// - Carrier bit rate is the clock divided by the divider field.
// - Integrator disabled means cleared and bypassed, sinc output passes through.
// - In sample-and-hold mode a hold trigger rising edge stores the accumulator and restarts it from any sample of that cycle.
// - Carrier generator runs only while its enable bit is set.
module itc_integrator_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [31:0] rdata,
    input wire logic [31:0] sincData,
    input wire logic sincValid,
    input wire logic modBit,
    input wire logic modClk,
    input wire logic holdTrigger0,
    input wire logic holdTrigger1,
    input wire logic phaseCalDone,
    output logic filterEnable,
    output logic [1:0] sincOrder,
    output logic [8:0] sincRatio,
    output logic demodActive,
    output logic dataReady,
    output logic carrierOutTrue,
    output logic carrierOutInverse
);
    itc_pkg::itc_main_s q, d;
    logic [15:0] timeValue;
    logic wrapPulse;
    logic modClkRise;
    logic holdSel;
    logic holdRise;
    logic syncRise;
    logic filtEnRise;
    logic bypass;
    logic sampleValid;
    logic [31:0] sampleVal;
    logic [33:0] sum;
    logic osrOvf;
    logic sahOvf;
    logic ovfSet;
    logic [7:0] ratioEff;
    logic statusRead;
    logic patWrite;
    itc_pkg::itc_integ_e nextState;

    // Keeps the ratio inside 1..128 so a stray zero cannot stall the count
    function automatic logic [7:0] itcRatio(input logic [7:0] r);
        if (r == 8'h00)
            itcRatio = 8'h01;
        else if (r > `ITC_INT_RATIO_MAX)
            itcRatio = `ITC_INT_RATIO_MAX;
        else
            itcRatio = r;
    endfunction

    // Sign bit is forced so a large offset never flips the apparent polarity
    function automatic logic [15:0] itcSlice(input logic [31:0] w, input logic [4:0] offs);
        logic [31:0] s;
        s = w >> offs;
        itcSlice = {w[31], s[14:0]};
    endfunction

    function automatic logic [33:0] itcExt(input logic [31:0] v);
        itcExt = {{2{v[31]}}, v};
    endfunction

    always_comb
    begin
        d = q;
        d.newData = 1'b0;
        modClkRise = modClk & ~q.modClkPrev;
        holdSel = q.ctrl[`ITC_CTRL_HSEL] ? holdTrigger1 : holdTrigger0;
        holdRise = holdSel & ~q.holdPrev;
        syncRise = q.ctrl[`ITC_CTRL_SYNC] & ~q.syncPrev;
        filtEnRise = q.ctrl[`ITC_CTRL_FILT_ON] & ~q.filtEnPrev;
        ratioEff = itcRatio(q.ratio[`ITC_RATIO_INT_LO +: 8]);
        statusRead = rdStrobe && (addr == `ITC_ADDR_STATUS);
        patWrite = wrStrobe && (addr == `ITC_ADDR_PATTERN);
        bypass = q.ctrl[`ITC_CTRL_FILT_ON]
            && (q.ctrl[`ITC_CTRL_ORDER_LO +: 2] == `ITC_ORDER_FIRST)
            && (q.ratio[`ITC_RATIO_SINC_LO +: 9] == `ITC_SINC_RATIO_ONE);
        sampleValid = bypass ? modClkRise : sincValid;
        sampleVal = bypass ? (modBit ? 32'h0000_0001 : 32'hFFFF_FFFF) : sincData;
        // Demodulation folds the negative carrier half into the sum
        if (q.demodActive && !carrierOutTrue)
            sampleVal = ~sampleVal + 32'h0000_0001;
        sum = itcExt(q.acc) + itcExt(sampleVal);
        osrOvf = !sum[33] ? (sum >= `ITC_ACC_POS) : (sum <= `ITC_ACC_NEG);
        sahOvf = !sum[33] ? (sum > `ITC_ACC_POS) : (sum < `ITC_ACC_NEG);
        ovfSet = 1'b0;

        case (q.state)
            itc_pkg::ITC_OFF:
            begin
                d.acc = 32'h0000_0000;
                d.cnt = 8'h00;
                if (sampleValid)
                begin
                    d.dataWord = sampleVal;
                    d.newData = 1'b1;
                end
            end
            itc_pkg::ITC_OSR:
            begin
                if (filtEnRise || syncRise)
                begin
                    d.acc = 32'h0000_0000;
                    d.cnt = 8'h00;
                end
                else if (sampleValid)
                begin
                    d.acc = sum[31:0];
                    if (osrOvf)
                    begin
                        ovfSet = 1'b1;
                        d.acc = 32'h0000_0000;
                    end
                    if (q.cnt >= ratioEff - 8'h01)
                    begin
                        d.dataWord = sum[31:0];
                        d.acc = 32'h0000_0000;
                        d.cnt = 8'h00;
                        d.newData = 1'b1;
                    end
                    else
                        d.cnt = q.cnt + 8'h01;
                end
            end
            itc_pkg::ITC_SAH:
            begin
                if (holdRise)
                begin
                    d.dataWord = q.acc;
                    d.acc = sampleValid ? sampleVal : 32'h0000_0000;
                    d.newData = 1'b1;
                end
                else if (syncRise)
                    d.acc = 32'h0000_0000;
                else if (sampleValid)
                begin
                    d.acc = sum[31:0];
                    if (sahOvf)
                    begin
                        ovfSet = 1'b1;
                        d.acc = 32'h0000_0000;
                    end
                end
            end
            default:
            begin
                d.acc = 32'h0000_0000;
                d.cnt = 8'h00;
            end
        endcase

        if (!q.ctrl[`ITC_CTRL_INT_ON])
            nextState = itc_pkg::ITC_OFF;
        else if (q.ctrl[`ITC_CTRL_HOLD_MODE])
            nextState = itc_pkg::ITC_SAH;
        else
            nextState = itc_pkg::ITC_OSR;
        if (nextState != q.state)
        begin
            d.acc = 32'h0000_0000;
            d.cnt = 8'h00;
        end
        d.state = nextState;

        // Set beats the clearing read so no event is lost
        d.ovfFlag = (q.ovfFlag & ~statusRead) | ovfSet;
        d.wrapFlag = (q.wrapFlag & ~statusRead) | wrapPulse;
        d.demodActive = q.ctrl[`ITC_CTRL_DEMOD] & phaseCalDone;
        d.modClkPrev = modClk;
        d.holdPrev = holdSel;
        d.syncPrev = q.ctrl[`ITC_CTRL_SYNC];
        d.filtEnPrev = q.ctrl[`ITC_CTRL_FILT_ON];

        if (wrStrobe)
        begin
            case (addr)
                `ITC_ADDR_CTRL: d.ctrl = wdata;
                `ITC_ADDR_RATIO: d.ratio = {15'h0000, wdata[16:0]};
                `ITC_ADDR_LENGTH: d.length = wdata[9:0];
                `ITC_ADDR_DIVIDER: d.divider = wdata[16:0];
                default: d.length = q.length;
            endcase
        end

        if (rdStrobe)
        begin
            case (addr)
                `ITC_ADDR_CTRL: d.rdata = q.ctrl;
                `ITC_ADDR_RATIO: d.rdata = q.ratio;
                `ITC_ADDR_DATA:
                begin
                    if (q.ctrl[`ITC_CTRL_NARROW])
                        d.rdata = {{16{q.dataWord[31]}},
                            itcSlice(q.dataWord, q.ctrl[`ITC_CTRL_SLICE_LO +: 5])};
                    else
                        d.rdata = q.dataWord;
                end
                `ITC_ADDR_TIME: d.rdata = {16'h0000, timeValue};
                `ITC_ADDR_STATUS: d.rdata = {30'h0000_0000, q.wrapFlag, q.ovfFlag};
                `ITC_ADDR_LENGTH: d.rdata = {22'h00_0000, q.length};
                `ITC_ADDR_DIVIDER: d.rdata = {15'h0000, q.divider};
                default: d.rdata = `ITC_RST_VALUE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            q <= '0;
        else if (ce)
            q <= d;
    end

    itc_time_meter u_time (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .modTick(modClkRise),
        .timerMode(q.ctrl[`ITC_CTRL_TMODE]),
        .holdRise(holdRise),
        .newData(q.newData | sincValid),
        .timeValue(timeValue),
        .wrapPulse(wrapPulse)
    );

    itc_carrier_gen u_carrier (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .patWrite(patWrite),
        .patData(wdata[15:0]),
        .enable(q.divider[`ITC_DIV_EN]),
        .lengthCount(q.length),
        .divider(q.divider[15:0]),
        .carrierTrue(carrierOutTrue),
        .carrierInverse(carrierOutInverse)
    );

    assign rdata = q.rdata;
    assign filterEnable = q.ctrl[`ITC_CTRL_FILT_ON];
    assign sincOrder = q.ctrl[`ITC_CTRL_ORDER_LO +: 2];
    assign sincRatio = q.ratio[`ITC_RATIO_SINC_LO +: 9];
    assign demodActive = q.demodActive;
    assign dataReady = q.newData;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    a_off_cleared: assert property (q.state == itc_pkg::ITC_OFF |-> q.acc == 32'h0000_0000)
        else $error("accumulator not cleared while disabled");
    a_osr_count: assert property (q.state == itc_pkg::ITC_OSR |-> q.cnt < ratioEff)
        else $error("sample count exceeds ratio");
    a_osr_restart: assert property (
        (ce && q.state == itc_pkg::ITC_OSR && filtEnRise) |=> q.acc == 32'h0000_0000)
        else $error("enable edge did not restart integration");
    a_ovf_flag: assert property ((ce && ovfSet) |=> q.ovfFlag && q.acc == 32'h0000_0000)
        else $error("overflow not flagged and cleared");
    a_sah_store: assert property (
        (ce && q.state == itc_pkg::ITC_SAH && holdRise) |=> q.dataWord == $past(q.acc))
        else $error("hold edge did not store accumulator");
    a_status_clear: assert property (
        (ce && statusRead && !wrapPulse) |=> !q.wrapFlag)
        else $error("status read left wrap flag set");
    a_demod_gate: assert property (q.demodActive |-> $past(phaseCalDone))
        else $error("demodulation active before calibration");
    a_slice_sign: assert property (
        (ce && rdStrobe && addr == `ITC_ADDR_DATA && q.ctrl[`ITC_CTRL_NARROW])
        |=> q.rdata[15] == $past(q.dataWord[31]))
        else $error("slice lost the sign");
    c_ovf: cover property (ce && ovfSet);
    c_sah: cover property (q.state == itc_pkg::ITC_SAH && holdRise ##1 dataReady);
    c_osr_done: cover property (q.state == itc_pkg::ITC_OSR ##1 dataReady);
endmodule

/* File: itc_mod_model.sv */
// Modulator model: bursts of modulator clock with a fixed bit pattern.
// Assumes run comes from the clk domain; clock stands low outside bursts.
`timescale 1ns/1ns
module itc_mod_model (
    input wire logic clk,
    input wire logic run,
    output logic modClk,
    output logic modBit
);
    localparam logic [7:0] BITS = 8'hD7;
    logic [1:0] phase;
    logic [2:0] idx;
    initial
    begin
        phase = 2'h0;
        idx = 3'h0;
        modClk = 1'b0;
        modBit = 1'b0;
    end
    always @(posedge clk)
    begin
        if (!run)
        begin
            // Idle data keeps moving so a stale bit is never mistaken for data
            phase <= 2'h0;
            modClk <= 1'b0;
            modBit <= ~modBit;
        end
        else
        begin
            phase <= phase + 2'h1;
            if (phase == 2'h0)
            begin
                modBit <= BITS[idx];
                idx <= idx + 3'h1;
            end
            if (phase == 2'h1)
                modClk <= 1'b1;
            if (phase == 2'h3)
                modClk <= 1'b0;
        end
    end
endmodule

/* File: itc_pkg.sv */
// Types shared by the integrator channel, its time meter and carrier generator.
// Assumes itc_defines.svh is included by each user file.
package itc_pkg;
    typedef enum logic [1:0] {ITC_OFF = 2'b00, ITC_OSR = 2'b01, ITC_SAH = 2'b11} itc_integ_e;

    typedef struct packed {
        itc_integ_e state;
        logic [31:0] ctrl;
        logic [31:0] ratio;
        logic [9:0] length;
        logic [16:0] divider;
        logic [31:0] acc;
        logic [7:0] cnt;
        logic [31:0] dataWord;
        logic ovfFlag;
        logic wrapFlag;
        logic [31:0] rdata;
        logic modClkPrev;
        logic holdPrev;
        logic syncPrev;
        logic filtEnPrev;
        logic newData;
        logic demodActive;
    } itc_main_s;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] timeReg;
        logic wrap;
    } itc_timer_s;

    typedef struct packed {
        logic [1023:0] pattern;
        logic loaded;
        logic [9:0] bitPtr;
        logic [15:0] divCnt;
        logic outTrue;
        logic outInv;
    } itc_carrier_s;
endpackage

/* File: itc_time_meter.sv */
// 16-bit time measure counter with time register and wrap pulse.
// Assumes tick and hold edge pulses are one cycle wide in the clk domain.
`timescale 1ns/1ns
`include "itc_defines.svh"
module itc_time_meter (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic modTick,
    input wire logic timerMode,
    input wire logic holdRise,
    input wire logic newData,
    output logic [15:0] timeValue,
    output logic wrapPulse
);
    itc_pkg::itc_timer_s q, d;
    logic cntTick;

    always_comb
    begin
        d = q;
        d.wrap = 1'b0;
        cntTick = timerMode ? modTick : 1'b1;
        if (holdRise)
        begin
            d.timeReg = q.count;
            d.count = 16'h0000;
        end
        else if (!timerMode && newData)
            d.count = 16'h0000;
        else if (cntTick)
        begin
            d.count = q.count + 16'h0001;
            d.wrap = (q.count == `ITC_TIME_MAX);
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            q <= '0;
        else if (ce)
            q <= d;
    end

    assign timeValue = q.timeReg;
    assign wrapPulse = q.wrap;

    a_wrap_cause: assert property (@(posedge clk) disable iff (srst)
        $rose(q.wrap) |-> $past(q.count) == 16'hFFFF && q.count == 16'h0000)
        else $error("wrap pulse without rollover");
    a_hold_load: assert property (@(posedge clk) disable iff (srst)
        (ce && holdRise) |=> q.timeReg == $past(q.count) && q.count == 16'h0000)
        else $error("hold edge did not load time register");
    c_wrap: cover property (@(posedge clk) disable iff (srst) $rose(q.wrap));
endmodule

/* File: testbench.sv */
// Self-checking bench for the integrator channel and carrier generator.
// Assumes the channel top and the modulator model are compiled alongside.
`timescale 1ns/1ns
`include "itc_defines.svh"
module testbench;
    localparam logic [31:0] PAT = 32'hA5C3_0F0F;
    logic clk;
    logic srst;
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wrStrobe;
    logic rdStrobe;
    logic [31:0] rdata;
    logic [31:0] sincData;
    logic sincValid;
    logic modBit;
    logic modClk;
    logic run;
    logic hold1;
    logic calDone;
    logic demodActive;
    logic dataReady;
    logic carTrue;
    logic carInv;
    logic filter_enable;
    logic [1:0] sOrd;
    logic [8:0] sRat;
    logic [31:0] rd;
    int errors;
    int checked;

    itc_integrator_top i_dut (.clk(clk), .srst(srst), .ce(1'b1), .addr(addr),
        .wdata(wdata), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdata(rdata),
        .sincData(sincData), .sincValid(sincValid), .modBit(modBit),
        .modClk(modClk), .holdTrigger0(1'b0), .holdTrigger1(hold1),
        .phaseCalDone(calDone), .filterEnable(filter_enable), .sincOrder(sOrd), .sincRatio(sRat),
        .demodActive(demodActive), .dataReady(dataReady),
        .carrierOutTrue(carTrue), .carrierOutInverse(carInv));
    itc_mod_model i_mod (.clk(clk), .run(run), .modClk(modClk), .modBit(modBit));

    always #2 clk = ~clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask
    task automatic rdr(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1 rd = rdata;
    endtask
    task automatic sample(input logic [31:0] v);
        @(posedge clk);
        sincData <= v;
        sincValid <= 1'b1;
        @(posedge clk);
        sincValid <= 1'b0;
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (dataReady !== 1'b1 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        chk({31'h0, dataReady}, 32'h1);
    endtask
    task automatic hold_edge();
        @(posedge clk);
        hold1 <= 1'b1;
        @(posedge clk);
        hold1 <= 1'b0;
        wait_ready();
    endtask
    task automatic t_reset();
        rdr(`ITC_ADDR_CTRL);
        chk(rd, 32'h0);
        rdr(4'hF);
        chk(rd, 32'h0);
        wr(`ITC_ADDR_DATA, 32'hFFFF_FFFF);
        rdr(`ITC_ADDR_DATA);
        chk(rd, 32'h0);
    endtask
    task automatic t_osr();
        wr(`ITC_ADDR_RATIO, 32'h2);
        wr(`ITC_ADDR_CTRL, 32'h1);
        sample(32'h5);
        sample(32'h7);
        wait_ready();
        rdr(`ITC_ADDR_DATA);
        chk(rd, 32'hC);
        // Two halves meet the limit exactly
        sample(32'h4000_0000);
        sample(32'h4000_0000);
        repeat (3) @(posedge clk);
        rdr(`ITC_ADDR_STATUS);
        chk(rd & 32'h1, 32'h1);
        rdr(`ITC_ADDR_STATUS);
        chk(rd & 32'h1, 32'h0);
        sample(32'h3);
        sample(32'hFFFF_FFFC);
        wait_ready();
        rdr(`ITC_ADDR_DATA);
        chk(rd, 32'hFFFF_FFFF);
    endtask
    task automatic t_restart();
        // Ratio two is still set; each restart drops the half-summed 5
        sample(32'h5);
        wr(`ITC_ADDR_CTRL, 32'h9);
        sample(32'h2);
        sample(32'h3);
        wait_ready();
        rdr(`ITC_ADDR_DATA);
        chk(rd, 32'h5);
        sample(32'h5);
        wr(`ITC_ADDR_CTRL, 32'h89);
        sample(32'h2);
        sample(32'h3);
        wait_ready();
        rdr(`ITC_ADDR_DATA);
        chk(rd, 32'h5);
        // Hold mode: the second full-scale word overflows, then 5 is summed
        wr(`ITC_ADDR_CTRL, 32'h43);
        sample(32'h7FFF_FFFF);
        sample(32'h7FFF_FFFF);
        sample(32'h5);
        hold_edge();
        rdr(`ITC_ADDR_DATA);
        chk(rd, 32'h5);
        rdr(`ITC_ADDR_STATUS);
        chk(rd & 32'h1, 32'h1);
    endtask
    task automatic t_slice();
        // The first word fits the slice; the others only keep their sign
        logic [31:0] w [3] = '{32'h00AB_CD00, 32'h0123_4567, 32'hF012_3456};
        logic [31:0] e [3] = '{32'h0000_55E6, 32'h0000_11A2, 32'hFFFF_9A2B};
        logic [4:0] offs [3] = '{5'h09, 5'h09, 5'h01};
        wr(`ITC_ADDR_RATIO, 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            wr(`ITC_ADDR_CTRL, {11'h000, offs[i], 16'h0005});
            sample(w[i]);
            wait_ready();
            rdr(`ITC_ADDR_DATA);
            chk(rd, e[i]);
        end
    endtask
    task automatic t_off();
        // Ratio two shows that the word did not wait for a second sample
        wr(`ITC_ADDR_RATIO, 32'h2);
        wr(`ITC_ADDR_CTRL, 32'h0);
        sample(32'h63);
        wait_ready();
        rdr(`ITC_ADDR_DATA);
        chk(rd, 32'h63);
    endtask
    task automatic t_bypass();
        // Raw bits, hold on trigger one, time in modulator clocks
        wr(`ITC_ADDR_RATIO, 32'h100);
        wr(`ITC_ADDR_CTRL, 32'h16B);
        hold_edge();
        chk({20'h0, filter_enable, sOrd, sRat}, 32'h0000_0A01);
        @(posedge clk);
        run <= 1'b1;
        repeat (32) @(posedge clk);
        run <= 1'b0;
        hold_edge();
        rdr(`ITC_ADDR_DATA);
        chk(rd, 32'h4);
        rdr(`ITC_ADDR_TIME);
        chk(rd, 32'h8);
    endtask
    task automatic t_demod();
        wr(`ITC_ADDR_CTRL, 32'h10);
        repeat (3) @(negedge clk);
        chk({31'h0, demodActive}, 32'h0);
        @(posedge clk);
        calDone <= 1'b1;
        repeat (3) @(negedge clk);
        chk({31'h0, demodActive}, 32'h1);
        wr(`ITC_ADDR_CTRL, 32'h0);
        repeat (3) @(negedge clk);
        chk({31'h0, demodActive}, 32'h0);
    endtask
    task automatic t_carrier();
        logic s [0:199];
        bit found;
        bit ok;
        wr(`ITC_ADDR_PATTERN, 32'hA5C3);
        wr(`ITC_ADDR_PATTERN, 32'h0F0F);
        wr(`ITC_ADDR_LENGTH, 32'h1F);
        wr(`ITC_ADDR_DIVIDER, 32'h0001_0003);
        repeat (10) @(negedge clk);
        for (int k = 0; k < 200; k++)
        begin
            @(negedge clk);
            s[k] = carTrue;
            chk({31'h0, carInv ^ carTrue}, 32'h1);
        end
        // Phase of the first bit is not fixed, so search all of them
        found = 0;
        for (int p = 0; p < 96; p++)
        begin
            ok = 1;
            for (int k = 0; k < 200; k++)
                if (s[k] !== PAT[31 - ((k + p) / 3) % 32])
                    ok = 0;
            found |= ok;
        end
        chk({31'h0, found}, 32'h1);
        wr(`ITC_ADDR_DIVIDER, 32'h0);
        repeat (5) @(negedge clk);
        chk({30'h0, carTrue, carInv}, 32'h0);
    endtask
    task automatic t_time0();
        logic [31:0] first;
        first = 32'h0;
        wr(`ITC_ADDR_CTRL, 32'h40);
        for (int g = 0; g < 2; g++)
        begin
            sample(32'h1);
            repeat (10 + 5 * g) @(posedge clk);
            hold1 <= 1'b1;
            @(posedge clk);
            hold1 <= 1'b0;
            rdr(`ITC_ADDR_TIME);
            if (g == 0)
                first = rd;
        end
        chk(rd - first, 32'h5);
    endtask
    task automatic t_wrap();
        sample(32'h1);
        wait_ready();
        rdr(`ITC_ADDR_STATUS);
        repeat (65000) @(posedge clk);
        rdr(`ITC_ADDR_STATUS);
        chk(rd & 32'h2, 32'h0);
        repeat (600) @(posedge clk);
        rdr(`ITC_ADDR_STATUS);
        chk(rd & 32'h2, 32'h2);
        rdr(`ITC_ADDR_STATUS);
        chk(rd & 32'h2, 32'h0);
    endtask
    task automatic final_report();
        if (errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        srst = 1'b1;
        addr = 4'h0;
        wdata = 32'h0;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        sincData = 32'h0;
        sincValid = 1'b0;
        run = 1'b0;
        hold1 = 1'b0;
        calDone = 1'b0;
        errors = 0;
        checked = 0;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_osr();
        t_restart();
        t_slice();
        t_off();
        t_bypass();
        t_demod();
        t_carrier();
        t_time0();
        t_wrap();
        final_report();
    end
    // Whole run is near 66k cycles; a 90k-cycle limit keeps a hang short
    initial
    begin
        #360000;
        errors++;
        final_report();
    end
endmodule
